/* sfs_regs.svh */
// register offsets, field positions, reset values and timing counts of the flash sequencer
// assumes inclusion by bare name from the key gate, sequencer and bench modules; the package and latch memory do not include it
`ifndef SFS_REGS_SVH
`define SFS_REGS_SVH
`define SFS_OFF_CONTROL 4'h0
`define SFS_OFF_ADDR_LOW 4'h1
`define SFS_OFF_ADDR_HIGH 4'h2
`define SFS_OFF_KEY 4'h3
`define SFS_OFF_STATUS 4'h4
`define SFS_CTL_START 15
`define SFS_CTL_ERR 13
`define SFS_CTL_ERASE 6
`define SFS_CTL_TYPE_LSB 0
`define SFS_CTL_TYPE_W 4
`define SFS_CTL_WRMASK 16'h004F
`define SFS_CTL_RESET 16'h0000
`define SFS_ADDR_LOW_RESET 16'h0000
`define SFS_ADDR_HIGH_RESET 8'h00
`define SFS_KEY_FIRST 16'h0055
`define SFS_KEY_SECOND 16'h00AA
`define SFS_ROW_WORDS 32
`define SFS_ROW_BYTES 96
`define SFS_PANEL_ROWS 128
`define SFS_PROG_GROUP 4
`define SFS_TBLWR_CYCLES 2
`define SFS_CELL_NS 10000
`define SFS_CLK_MHZ 200
`define SFS_CELL_CYCLES ((`SFS_CELL_NS * `SFS_CLK_MHZ) / 1000)
`endif

/* sfs_pkg.sv */
// types shared by the flash sequencer modules
// needs nothing from sfs_regs.svh, which it does not include
package sfs_pkg;
    typedef enum logic [1:0] {
        SFS_IDLE = 2'b00,
        SFS_KEY1 = 2'b01,
        SFS_ARMED = 2'b11
    } sfs_key_t;
    typedef enum logic [1:0] {
        SFS_OP_IDLE = 2'b00,
        SFS_OP_RUN = 2'b01,
        SFS_OP_DONE = 2'b11
    } sfs_op_t;
endpackage

/* sfs_latch_mem.sv */
// write latches: 4 panels x 32 words of 24 bits, registered read port
// assumes one write per clock; read data appear one clock after rdAddr
`timescale 1ns/10ps
module sfs_latch_mem
    import sfs_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic wrEn, // write strobe
    input wire logic [6:0] wrAddr, // panel and word index
    input wire logic [23:0] wrData, // word data
    input wire logic [2:0] wrMask, // byte lanes low, mid, high
    input wire logic [6:0] rdAddr, // read index
    output logic [23:0] rdData_q // registered read data
);
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gLane
            // one memory per byte lane, so each lane has a single writer
            logic [7:0] laneMem [0:127];
            logic [7:0] laneRd_q;
            always_ff @(posedge sys_clk) begin
                if (wrEn && wrMask[g]) begin
                    laneMem[wrAddr] <= wrData[g*8 +: 8];
                end
            end
            always_ff @(posedge sys_clk) begin
                laneRd_q <= laneMem[rdAddr];
            end
            assign rdData_q[g*8 +: 8] = laneRd_q;
        end
    endgenerate
endmodule // sfs_latch_mem

/* sfs_key_gate.sv */
// unlock key checker: 0x55 then 0xAA with no access in between arms one start
// assumes access is a one-cycle pulse per completed bus access
`timescale 1ns/10ps
`include "sfs_regs.svh"
module sfs_key_gate
    import sfs_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic reset, // synchronous reset, active high
    input wire logic access, // any register access pulse
    input wire logic keyWr, // write pulse to key register
    input wire logic [15:0] keyData, // key data written
    input wire logic consume, // start attempt consumes arming
    output logic armed_q // unlock held
);
    sfs_key_t state_q;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q <= SFS_IDLE;
        end else if (access) begin
            case (state_q)
                SFS_IDLE: state_q <= (keyWr && keyData == `SFS_KEY_FIRST) ? SFS_KEY1 : SFS_IDLE;
                SFS_KEY1: state_q <= (keyWr && keyData == `SFS_KEY_SECOND) ? SFS_ARMED :
                    (keyWr && keyData == `SFS_KEY_FIRST) ? SFS_KEY1 : SFS_IDLE;
                default: state_q <= (keyWr && keyData == `SFS_KEY_FIRST) ? SFS_KEY1 : SFS_IDLE;
            endcase
        end
    end
    // start write consumes arming in the same access that tests it
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= (state_q == SFS_ARMED) && !access && !consume;
        end
    end
endmodule // sfs_key_gate

/* sfs_flash_seq.sv */
// flash sequencer: Avalon-MM slave registers, table-write port, flash cell port
// assumes the cell is a 24-bit array addressed by word, one write per cell pulse
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "sfs_regs.svh"
module sfs_flash_seq
    import sfs_pkg::*;
(
    input wire logic sys_clk, // 200 MHz clock
    input wire logic reset, // synchronous reset, active high
    input wire logic [3:0] avs_address, // word index
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    input wire logic tblWrLow, // table write low word strobe
    input wire logic tblWrHigh, // table write high word strobe
    input wire logic [23:0] effAddr, // table effective address
    input wire logic [15:0] tblData, // table write data
    output logic tblBusy_q, // table write in its 2nd cycle
    output logic cellWrite_q, // flash word write strobe
    output logic cellErase_q, // flash row erase strobe
    output logic [23:0] cellAddr_q, // flash word address
    output logic [23:0] cellData_q, // flash word data
    output logic busy_q // sequence running
);
    logic [15:0] ctl_q;
    logic [15:0] addrLow_q;
    logic [7:0] addrHigh_q;
    logic armed;
    logic access;
    logic doWr;
    logic doRd;
    logic startTry;
    logic tblPhase_q;
    logic [23:0] tblAddr_q;
    logic [15:0] tblData_q;
    logic tblHigh_q;
    logic [6:0] rdIdx;
    logic [23:0] latchWord;
    sfs_op_t op_q;
    logic [4:0] word_q;
    logic [1:0] group_q;
    logic [15:0] waitCnt_q;
    logic [31:0] rdNext;
    logic avsReq;
    logic tblTake;
    logic ctlWr;
    logic keyWr;
    logic running;
    logic eraseOn;
    logic progStep;
    logic groupEnd;
    logic rowEnd;
    logic eraseStart;
    logic eraseEnd;
    logic settleEnd;

    // two panel bits only: latch sets repeat every four panels
    function automatic logic [6:0] latchIndex(input logic [23:0] a);
        latchIndex = {a[14:13], a[5:1]}; // 128 rows of 64 addresses per panel
    endfunction

    // waitrequest low on second cycle so every access takes exactly two edges
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !(avsReq && avs_waitrequest);
        end
    end
    assign doWr = avs_write && !avs_waitrequest;
    assign doRd = avs_read && !avs_waitrequest;
    assign access = doWr || doRd;
    assign startTry = doWr && avs_address == `SFS_OFF_CONTROL && avs_writedata[`SFS_CTL_START];
    assign avsReq = avs_read || avs_write;
    // a strobe in the second cycle or while busy is dropped, not queued
    assign tblTake = (tblWrLow || tblWrHigh) && !tblPhase_q && !busy_q;
    assign ctlWr = doWr && avs_address == `SFS_OFF_CONTROL && !busy_q;
    assign keyWr = doWr && avs_address == `SFS_OFF_KEY;

    sfs_key_gate uKey (
        .sys_clk(sys_clk),
        .reset(reset),
        .access(access),
        .keyWr(keyWr),
        .keyData(avs_writedata[15:0]),
        .consume(startTry),
        .armed_q(armed)
    );

    // table write: capture in cycle 1, latch write in cycle 2
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tblPhase_q <= 1'b0;
        end else begin
            tblPhase_q <= tblTake;
        end
    end

    // capture holds until the next taken write, past the latch write
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tblAddr_q <= 24'h000000;
            tblData_q <= 16'h0000;
            tblHigh_q <= 1'b0;
        end else if (tblTake) begin
            tblAddr_q <= effAddr;
            tblData_q <= tblData;
            tblHigh_q <= tblWrHigh;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tblBusy_q <= 1'b0;
        end else begin
            tblBusy_q <= tblTake;
        end
    end

    // per-panel latches, addressed by panel and word within row
    sfs_latch_mem uLatch (
        .sys_clk(sys_clk),
        .wrEn(tblPhase_q),
        .wrAddr(latchIndex(tblAddr_q)),
        .wrData(tblHigh_q ? {tblData_q[7:0], 16'h0000} : {8'h00, tblData_q}),
        .wrMask(tblHigh_q ? 3'b100 : 3'b011),
        .rdAddr(rdIdx),
        .rdData_q(latchWord)
    );
    assign rdIdx = {addrLow_q[14:13], word_q};

    // address registers: hardware capture from table writes, or direct writes
    // capture wins over a direct write landing in the same cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            addrLow_q <= `SFS_ADDR_LOW_RESET;
        end else if (tblPhase_q) begin
            addrLow_q <= tblAddr_q[15:0];
        end else if (doWr && !busy_q && avs_address == `SFS_OFF_ADDR_LOW) begin
            addrLow_q <= avs_writedata[15:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            addrHigh_q <= `SFS_ADDR_HIGH_RESET;
        end else if (tblPhase_q) begin
            addrHigh_q <= tblAddr_q[23:16];
        end else if (doWr && !busy_q && avs_address == `SFS_OFF_ADDR_HIGH) begin
            addrHigh_q <= avs_writedata[7:0];
        end
    end

    // control: erase select, memory type, start; start gated by the key
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctl_q <= `SFS_CTL_RESET;
        end else begin
            // any start attempt spends the arming, so a refused one needs a new key pair
            if (ctlWr) begin
                ctl_q <= (avs_writedata[15:0] & `SFS_CTL_WRMASK) | (ctl_q & ~`SFS_CTL_WRMASK);
                ctl_q[`SFS_CTL_START] <= avs_writedata[`SFS_CTL_START] && armed;
                ctl_q[`SFS_CTL_ERR] <= avs_writedata[`SFS_CTL_START] && !armed;
            end
            if (op_q == SFS_OP_DONE) begin
                ctl_q[`SFS_CTL_START] <= 1'b0;
            end
        end
    end

    // sequence: erase pulses once per row; program walks the row in groups of four
    assign running = op_q == SFS_OP_RUN;
    assign eraseOn = running && ctl_q[`SFS_CTL_ERASE];
    assign progStep = running && !ctl_q[`SFS_CTL_ERASE] && waitCnt_q == 16'h0001;
    assign groupEnd = group_q == 2'(`SFS_PROG_GROUP - 1);
    assign rowEnd = word_q == 5'(`SFS_ROW_WORDS - 1);
    assign eraseStart = eraseOn && waitCnt_q == 16'h0000;
    assign eraseEnd = eraseOn && waitCnt_q == 16'(`SFS_CELL_CYCLES - 1);
    assign settleEnd = waitCnt_q == 16'(`SFS_CELL_CYCLES);

    // operation state and busy level
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            op_q <= SFS_OP_IDLE;
            busy_q <= 1'b0;
        end else begin
            case (op_q)
                SFS_OP_IDLE: begin
                    if (ctl_q[`SFS_CTL_START]) begin
                        op_q <= SFS_OP_RUN;
                        busy_q <= 1'b1;
                    end
                end
                SFS_OP_RUN: begin
                    if (eraseEnd || (progStep && rowEnd)) begin
                        op_q <= SFS_OP_DONE;
                    end
                end
                SFS_OP_DONE: begin
                    op_q <= SFS_OP_IDLE;
                    busy_q <= 1'b0;
                end
                default: op_q <= SFS_OP_IDLE;
            endcase
        end
    end

    // cell timer: erase time, or word pacing and group settle when programming
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            waitCnt_q <= 16'h0000;
        end else if (!running) begin
            waitCnt_q <= 16'h0000;
        end else if (ctl_q[`SFS_CTL_ERASE]) begin
            waitCnt_q <= waitCnt_q + 16'h0001;
        end else if (progStep) begin
            waitCnt_q <= groupEnd ? 16'h0002 : 16'h0000;
        end else if (waitCnt_q >= 16'h0002) begin
            // group settle time before the next four words
            waitCnt_q <= settleEnd ? 16'h0000 : waitCnt_q + 16'h0001;
        end else begin
            waitCnt_q <= 16'h0001;
        end
    end

    // word walk; one latch word every two clocks since the read port lags a cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            word_q <= 5'h00;
            group_q <= 2'h0;
        end else if (op_q == SFS_OP_IDLE) begin
            word_q <= 5'h00;
            group_q <= 2'h0;
        end else if (progStep) begin
            word_q <= word_q + 5'h01;
            group_q <= group_q + 2'h1;
        end
    end

    // cell strobes, one clock each
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cellWrite_q <= 1'b0;
            cellErase_q <= 1'b0;
        end else begin
            cellWrite_q <= progStep;
            cellErase_q <= eraseStart;
        end
    end

    // cell address and data, valid with their strobe
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cellAddr_q <= 24'h000000;
            cellData_q <= 24'h000000;
        end else if (eraseStart) begin
            cellAddr_q <= {addrHigh_q, addrLow_q[15:6], 6'h00};
        end else if (progStep) begin
            cellAddr_q <= {addrHigh_q, addrLow_q[15:6], word_q, 1'b0};
            cellData_q <= latchWord;
        end
    end

    // reads: key register reads zero as it is write-only
    always_comb begin
        rdNext = 32'h00000000;
        if (avs_address == `SFS_OFF_CONTROL) begin
            rdNext = {16'h0000, ctl_q};
        end else if (avs_address == `SFS_OFF_ADDR_LOW) begin
            rdNext = {16'h0000, addrLow_q};
        end else if (avs_address == `SFS_OFF_ADDR_HIGH) begin
            rdNext = {24'h000000, addrHigh_q};
        end else if (avs_address == `SFS_OFF_STATUS) begin
            rdNext = {29'h00000000, armed, tblPhase_q, busy_q};
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= rdNext;
        end
    end
endmodule // sfs_flash_seq

/* sfs_flash_seq_assertions.sv */
// port checker for the flash sequencer
// assumes binding to sfs_flash_seq, one clock domain
`timescale 1ns/10ps
module sfs_flash_seq_assertions
    import sfs_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire logic reset, // sync reset
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic avs_waitrequest, // stall
    input wire logic tblWrLow, // low strobe
    input wire logic tblWrHigh, // high strobe
    input wire logic tblBusy_q, // table 2nd cycle
    input wire logic cellWrite_q, // word write
    input wire logic cellErase_q, // row erase
    input wire logic [23:0] cellAddr_q, // cell address
    input wire logic busy_q // running
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence busReq;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence tblTaken;
        (tblWrLow || tblWrHigh) && !tblBusy_q && !busy_q;
    endsequence
    a_bus_answer: assert property (busReq |=> !avs_waitrequest)
        else $error("bus access not answered in one cycle");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_tbl_two_cycle: assert property (tblTaken |=> tblBusy_q ##1 !tblBusy_q)
        else $error("table write not two cycles");
    a_tbl_refused: assert property (busy_q && tblWrLow && !tblBusy_q |=> !tblBusy_q)
        else $error("table write taken while busy");
    a_erase_row: assert property (cellErase_q |-> cellAddr_q[5:0] == 6'h00 ##1 !cellErase_q)
        else $error("erase not a single row pulse");
    a_word_even: assert property (cellWrite_q |-> cellAddr_q[0] == 1'b0 && busy_q)
        else $error("cell write address odd or idle");
    a_cell_excl: assert property (!(cellWrite_q && cellErase_q))
        else $error("write and erase together");
    a_erase_busy: assert property (cellErase_q |-> busy_q)
        else $error("erase outside a sequence");
endmodule // sfs_flash_seq_assertions

bind sfs_flash_seq sfs_flash_seq_assertions u_chk (.sys_clk(sys_clk), .reset(reset),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .tblWrLow(tblWrLow), .tblWrHigh(tblWrHigh), .tblBusy_q(tblBusy_q),
    .cellWrite_q(cellWrite_q), .cellErase_q(cellErase_q), .cellAddr_q(cellAddr_q),
    .busy_q(busy_q));

/* sfs_flash_seq_test.sv */
// self-checking bench for the flash sequencer
// assumes the design package and register header are compiled first
`timescale 1ns/10ps
`include "sfs_regs.svh"
module sfs_flash_seq_test
    import sfs_pkg::*;
;
    logic sys_clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic tblWrLow = 1'b0, tblWrHigh = 1'b0, avs_waitrequest, tblBusy_q;
    logic cellWrite_q, cellErase_q, busy_q;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, seed, r;
    logic [23:0] effAddr = 24'h0, cellAddr_q, cellData_q, base, ra;
    logic [15:0] tblData = 16'h0;
    logic [47:0] rdQ[$], cellQ[$];
    int failCount = 0, nChecks = 0;
    sfs_flash_seq dut (.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .tblWrLow(tblWrLow), .tblWrHigh(tblWrHigh), .effAddr(effAddr),
        .tblData(tblData), .tblBusy_q(tblBusy_q), .cellWrite_q(cellWrite_q),
        .cellErase_q(cellErase_q), .cellAddr_q(cellAddr_q),
        .cellData_q(cellData_q), .busy_q(busy_q));
    always #2.5 sys_clk = ~sys_clk;
    task automatic complete_run();
        $display("checks=%0d errors=%0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        nChecks++;
        if (got !== exp) begin
            failCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // request held until the edge that samples waitrequest low
    task automatic bus(input logic [3:0] a, input logic wr, input logic [15:0] d);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {16'h0000, d};
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        rdQ.push_back({16'h0000, exp});
        bus(a, 1'b0, 16'h0000);
    endtask
    // strobe one cycle, next strobe two cycles later
    task automatic tbl(input logic hi, input logic [23:0] ea, input logic [15:0] d);
        tblWrLow <= !hi;
        tblWrHigh <= hi;
        effAddr <= ea;
        tblData <= d;
        @(posedge sys_clk);
        tblWrLow <= 1'b0;
        tblWrHigh <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic start(input logic [15:0] ctl);
        bus(4'h3, 1'b1, 16'h0055);
        bus(4'h3, 1'b1, 16'h00AA);
        bus(4'h0, 1'b1, ctl);
    endtask
    // busy rises a clock after the start write lands, so look only after two edges
    task automatic wait_idle();
        repeat (2) @(posedge sys_clk);
        chk(48'(busy_q), 48'h1);
        for (int i = 0; i < 30000 && busy_q !== 1'b0; i++) @(posedge sys_clk);
        if (busy_q !== 1'b0) failCount++;
    endtask
    always @(posedge sys_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
            chk({16'h0000, avs_readdata}, rdQ.pop_front());
        if (cellWrite_q === 1'b1)
            chk({cellAddr_q, cellData_q}, cellQ.pop_front());
        if (cellErase_q === 1'b1)
            chk({cellAddr_q, 24'h000000}, cellQ.pop_front());
    end
    initial begin
        #200000;
        failCount++;
        complete_run();
    end
    initial begin
        seed = 32'hb5e8;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rd(4'h0, 32'h0);
        rd(4'h1, 32'h0);
        rd(4'h2, 32'h0);
        rd(4'hF, 32'h0);
        base = 24'h021040; // one panel, row aligned, filled ascending
        // one latch row, ascending and aligned; expectations kept in order
        for (int w = 0; w < 32; w++) begin
            r = $random(seed);
            tbl(1'b0, base + 24'(2 * w), r[15:0]);
            tbl(1'b1, base + 24'(2 * w), {8'h00, r[23:16]});
            cellQ.push_back({base + 24'(2 * w), r[23:0]});
        end
        rd(4'h1, {16'h0000, base[15:0] + 16'h003E});
        rd(4'h2, {24'h000000, base[23:16]});
        // intervening access disarms the key, so start must be refused
        bus(4'h3, 1'b1, 16'h0055);
        bus(4'h3, 1'b1, 16'h00AA);
        rd(4'h4, 32'h4);
        bus(4'h0, 1'b1, 16'h8001);
        rd(4'h0, 32'h2001);
        rd(4'h4, 32'h0);
        start(16'h8001);
        tbl(1'b0, 24'h000000, 16'h1234);
        wait_idle();
        rd(4'h1, {16'h0000, base[15:0] + 16'h003E});
        r = $random(seed);
        ra = r[23:0];
        bus(4'h1, 1'b1, ra[15:0]);
        bus(4'h2, 1'b1, {8'h00, ra[23:16]});
        rd(4'h1, {16'h0000, ra[15:0]});
        rd(4'h2, {24'h000000, ra[23:16]});
        cellQ.push_back({ra[23:6], 6'h00, 24'h000000});
        start(16'h8040);
        wait_idle();
        rd(4'h4, 32'h0);
        chk(48'(cellQ.size() + rdQ.size()), 48'h0);
        complete_run();
    end
endmodule // sfs_flash_seq_test
